// ===== rtl/pps_pkg.sv
// Purpose: constants shared by the phase-step control block
// Assumes: system clock clk at 20 MHz samples the reconfiguration clock
// Notes: target select codes follow the counter select map
package pps_pkg;
	localparam int PPS_CLK_HZ = 20000000;
	localparam int PPS_TAPS = 8;
	localparam int PPS_TAP_W = 3;
	localparam int PPS_NUM_C = 5;
	localparam int PPS_SEL_W = 3;
	localparam logic [2:0] PPS_SEL_ALL = 3'h0;
	localparam logic [2:0] PPS_SEL_M = 3'h1;
	localparam logic [2:0] PPS_SEL_C0 = 3'h2;
	localparam logic [2:0] PPS_SEL_C4 = 3'h6;
	localparam logic [2:0] PPS_SEL_NONE = 3'h7;
	localparam logic [2:0] PPS_TAP_RST = 3'h0;
	localparam int PPS_RISE_WAIT = 2;
	localparam int PPS_SETTLE_CYC = 3;
	localparam int PPS_SETTLE_W = 4;
	localparam logic [3:0] PPS_SETTLE_RST = 4'h0;
	typedef enum logic [1:0] {PPS_IDLE, PPS_ARMED, PPS_SHIFT, PPS_HOLD} pps_state_e;
endpackage

// ===== rtl/pps_tap.sv
// Purpose: one phase-tap selector, stepped one eighth of the oscillation at a time
// Assumes: step is a one-cycle pulse on clk
// Notes: wraps around the ring of taps in both directions
`timescale 1ns/1ps
module pps_tap #(
	parameter int TAP_W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// step control
	input wire logic step,
	input wire logic up,
	// selected tap
	output logic [TAP_W-1:0] tap
);
	logic [TAP_W-1:0] tap_r;
	logic [TAP_W-1:0] tap_nxt;
	// next tap: exactly one position per step, up or down
	always_comb begin
		tap_nxt = tap_r;
		if (step) begin
			if (up)
				tap_nxt = tap_r + TAP_W'(1);
			else
				tap_nxt = tap_r - TAP_W'(1);
		end
	end
	always_ff @(posedge clk) begin
		if (rst)
			tap_r <= '0;
		else
			tap_r <= tap_nxt;
	end
	assign tap = tap_r;
endmodule

// ===== rtl/pps_ctrl.sv
// Purpose: dynamic phase-step handshake and phase-tap selection for M and C counters
// Assumes: scan clock arrives as a plain input, sampled by clk much faster than it
// Notes: output clocks are never gated; only the tap index moves
//
// What this block does
// - step the VCO tap for M or a C counter, no scan chain used
// - each step moves the phase by one eighth of the VCO period
// - output clocks keep running while the phase is moved
// - three-bit select picks M, one C counter, or all C counters
// - codes: 0 all, 1 M, 2..6 C0..C4, 7 unassigned
// - direction 1 shifts up, 0 shifts down
// - each step request pulse gives exactly one phase shift
// - the request is sampled on the scan clock falling edge
// - second rising edge after sampling captures select and direction, starts shifting
// - done drops on that same rising edge and stays low until finished
// - done rises from internal timing, not from the scan clock
// - everything is synchronous to clk; the free-running scan clock is only sampled
`timescale 1ns/1ps
module pps_ctrl
	import pps_pkg::*;
#(
	parameter int SETTLE_CYC = pps_pkg::PPS_SETTLE_CYC
) (
	// system clock and reset
	input wire logic clk,
	input wire logic rst,
	// phase-step handshake from core logic
	input wire logic scan_clk,
	input wire logic step_req,
	input wire logic step_up,
	input wire logic [pps_pkg::PPS_SEL_W-1:0] step_sel,
	output logic step_done,
	// tap selections feeding the counters
	output logic [pps_pkg::PPS_TAP_W-1:0] m_tap,
	output logic [pps_pkg::PPS_NUM_C*pps_pkg::PPS_TAP_W-1:0] c_tap
);
	import pps_pkg::*;

	// three-stage input synchronisers; stage 1 only feeds stage 2
	logic [2:0] sck_s_r;
	logic [2:0] req_s_r;
	logic [2:0] up_s_r;
	logic [2:0] sel0_s_r, sel1_s_r, sel2_s_r;
	logic sck_lvl_r, sck_lvl_nxt;
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_s_r <= 3'h0;
			req_s_r <= 3'h0;
			up_s_r <= 3'h0;
			sel0_s_r <= 3'h0;
			sel1_s_r <= 3'h0;
			sel2_s_r <= 3'h0;
			sck_lvl_r <= 1'b0;
		end else begin
			sck_s_r <= {sck_s_r[1:0], scan_clk};
			req_s_r <= {req_s_r[1:0], step_req};
			up_s_r <= {up_s_r[1:0], step_up};
			sel0_s_r <= {sel0_s_r[1:0], step_sel[0]};
			sel1_s_r <= {sel1_s_r[1:0], step_sel[1]};
			sel2_s_r <= {sel2_s_r[1:0], step_sel[2]};
			sck_lvl_r <= sck_lvl_nxt;
		end
	end
	// scan clock level changes only when stages two and three agree
	always_comb begin
		sck_lvl_nxt = sck_lvl_r;
		if (sck_s_r[1] == sck_s_r[2])
			sck_lvl_nxt = sck_s_r[2];
	end
	logic sck_rise, sck_fall;
	assign sck_rise = sck_lvl_nxt & ~sck_lvl_r;
	assign sck_fall = ~sck_lvl_nxt & sck_lvl_r;

	// handshake state
	pps_state_e st_r, st_nxt;
	logic req_seen_r, req_seen_nxt;
	logic [1:0] rise_cnt_r, rise_cnt_nxt;
	logic [PPS_SETTLE_W-1:0] settle_r, settle_nxt;
	logic done_r, done_nxt;
	logic up_r, up_nxt;
	logic [PPS_SEL_W-1:0] sel_r, sel_nxt;
	logic step_p_r, step_p_nxt;
	logic [PPS_SETTLE_W-1:0] settle_len;
	assign settle_len = PPS_SETTLE_W'(SETTLE_CYC);

	// next-state: sample on falling edge, act two rising edges later
	always_comb begin
		st_nxt = st_r;
		req_seen_nxt = req_seen_r;
		rise_cnt_nxt = rise_cnt_r;
		settle_nxt = settle_r;
		done_nxt = done_r;
		up_nxt = up_r;
		sel_nxt = sel_r;
		step_p_nxt = 1'b0;
		// a high request must drop before another is accepted
		if (sck_fall && !req_s_r[2])
			req_seen_nxt = 1'b0;
		case (st_r)
			PPS_IDLE: begin
				if (sck_fall && req_s_r[2] && !req_seen_r) begin
					req_seen_nxt = 1'b1;
					rise_cnt_nxt = 2'h0;
					st_nxt = PPS_ARMED;
				end
			end
			PPS_ARMED: begin
				if (sck_rise) begin
					rise_cnt_nxt = rise_cnt_r + 2'h1;
					if (rise_cnt_r == 2'(PPS_RISE_WAIT - 1)) begin
						up_nxt = up_s_r[2];
						sel_nxt = {sel2_s_r[2], sel1_s_r[2], sel0_s_r[2]};
						done_nxt = 1'b0;
						step_p_nxt = 1'b1;
						st_nxt = PPS_SHIFT;
					end
				end
			end
			PPS_SHIFT: begin
				// the taps move here; clocks stay running throughout
				settle_nxt = settle_len;
				st_nxt = PPS_HOLD;
			end
			PPS_HOLD: begin
				// internal timing ends the low period, independent of scan clock
				if (settle_r <= PPS_SETTLE_W'(1)) begin
					done_nxt = 1'b1;
					st_nxt = PPS_IDLE;
				end else begin
					settle_nxt = settle_r - PPS_SETTLE_W'(1);
				end
			end
			default: st_nxt = PPS_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= PPS_IDLE;
			req_seen_r <= 1'b0;
			rise_cnt_r <= 2'h0;
			settle_r <= PPS_SETTLE_RST;
			done_r <= 1'b1;
			up_r <= 1'b0;
			sel_r <= PPS_SEL_NONE;
			step_p_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			req_seen_r <= req_seen_nxt;
			rise_cnt_r <= rise_cnt_nxt;
			settle_r <= settle_nxt;
			done_r <= done_nxt;
			up_r <= up_nxt;
			sel_r <= sel_nxt;
			step_p_r <= step_p_nxt;
		end
	end
	assign step_done = done_r;

	// decode the target select into one step enable per counter
	logic m_step;
	logic [PPS_NUM_C-1:0] c_step;
	always_comb begin
		m_step = step_p_r && (sel_r == PPS_SEL_M);
		for (int i = 0; i < PPS_NUM_C; i++) begin
			c_step[i] = step_p_r && ((sel_r == PPS_SEL_ALL) ||
				(sel_r == PPS_SEL_C0 + 3'(i)));
		end
	end

	// tap selectors: index only, no scan transfer, no clock gating
	pps_tap #(.TAP_W(PPS_TAP_W)) u_m_tap (
		.clk(clk),
		.rst(rst),
		.step(m_step),
		.up(up_r),
		.tap(m_tap)
	);
	genvar g;
	generate
		for (g = 0; g < PPS_NUM_C; g++) begin : g_c
			pps_tap #(.TAP_W(PPS_TAP_W)) u_c_tap (
				.clk(clk),
				.rst(rst),
				.step(c_step[g]),
				.up(up_r),
				.tap(c_tap[g*PPS_TAP_W +: PPS_TAP_W])
			);
		end
	endgenerate
endmodule

// ===== sim/pps_sva.sv
// Purpose: checks on the phase-step outputs
// Assumes: settle count passed down from the block it is bound into
// Notes: sees the top ports only
`timescale 1ns/1ps
module pps_sva #(
	parameter int SETTLE_CYC = 3
) (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic step_done,
	input wire logic [2:0] m_tap,
	input wire logic [14:0] c_tap
);
	// one clock domain, reset masks all but the reset-value check
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// done stays low for the settle count plus the shift cycle
	localparam int DONE_LOW = SETTLE_CYC + 1;
	// tap moves caused by reset itself are masked by the past-reset term
	a_busy_taps_move: assert property (!$past(rst) && $changed({m_tap, c_tap}) |-> !step_done)
		else $error("taps moved while done high");
	a_m_one_step: assert property (!$past(rst) && $changed(m_tap)
		|-> 3'(m_tap - $past(m_tap)) inside {3'h1, 3'h7})
		else $error("m tap moved by more than one");
	a_c_one_step: assert property (!$past(rst) && $changed(c_tap[2:0])
		|-> 3'(c_tap[2:0] - $past(c_tap[2:0])) inside {3'h1, 3'h7})
		else $error("c0 tap moved by more than one");
	a_one_target: assert property (!$past(rst) && $changed(m_tap) |-> $stable(c_tap))
		else $error("m and c taps moved together");
	a_single_move: assert property (!$past(rst) && $changed({m_tap, c_tap})
		|=> $stable({m_tap, c_tap})[*8])
		else $error("second tap move in one step");
	a_done_low: assert property ($fell(step_done) |-> !step_done[*2])
		else $error("done low too briefly");
	a_done_back: assert property ($fell(step_done) |-> ##[DONE_LOW:DONE_LOW] step_done)
		else $error("done never rose");
	a_reset_vals: assert property (disable iff (1'b0) rst |=> step_done && {m_tap, c_tap} == 18'h0)
		else $error("reset values wrong");
endmodule
bind pps_ctrl pps_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (
	.clk(clk),
	.rst(rst),
	.step_done(step_done),
	.m_tap(m_tap),
	.c_tap(c_tap)
);

// ===== sim/pps_core_model.sv
// Purpose: core logic driving the step handshake
// Assumes: scan clock runs free
// Notes: hold length sets a prompt or slow request
`timescale 1ns/1ps
module pps_core_model (
	// system clock
	input wire logic clk,
	// handshake toward the block
	output logic scan_clk,
	output logic step_req,
	output logic step_up,
	output logic [2:0] step_sel
);
	// scan clock offset so its edges never meet clk edges
	initial begin
		{scan_clk, step_req, step_up, step_sel} = 6'h0;
		#37;
		forever #200 scan_clk = ~scan_clk;
	end
	// setup first, then hold the request n scan cycles
	task automatic step(input logic u, input logic [2:0] s, input int n);
		@(posedge scan_clk);
		@(negedge clk);
		step_up = u;
		step_sel = s;
		@(posedge scan_clk);
		@(negedge clk);
		step_req = 1'b1;
		repeat (n) @(posedge scan_clk);
		@(negedge clk);
		step_req = 1'b0;
	endtask
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench for the phase-step block
// Assumes: default settle count
// Notes: expected taps kept in em and ec
`timescale 1ns/1ps
module tb;
	import pps_pkg::*;
	logic clk, rst, scan_clk, step_req, step_up, step_done;
	logic [2:0] step_sel, m_tap, em;
	logic [14:0] c_tap, ec;
	int num_errors, total_checks;
	pps_core_model u_core (.clk(clk), .scan_clk(scan_clk), .step_req(step_req),
		.step_up(step_up), .step_sel(step_sel));
	pps_ctrl u_dut (.clk(clk), .rst(rst), .scan_clk(scan_clk), .step_req(step_req),
		.step_up(step_up), .step_sel(step_sel), .step_done(step_done),
		.m_tap(m_tap), .c_tap(c_tap));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// bounded wait for done to fall and then rise
	task automatic wait_done();
		int k;
		int j;
		// looked at on the falling edge, where done has settled
		for (k = 0; k < 400 && step_done !== 1'b0; k++) @(negedge clk);
		for (j = 0; j < 400 && step_done !== 1'b1; j++) @(negedge clk);
		if (k >= 400 || j >= 400) begin
			num_errors++;
			report_and_stop();
		end
	endtask
	task automatic step(input logic u, input logic [2:0] s, input int n);
		logic [2:0] d;
		d = u ? 3'h1 : 3'h7;
		if (s == PPS_SEL_M)
			em = em + d;
		for (int c = 0; c < PPS_NUM_C; c++)
			if (s == PPS_SEL_ALL || s == PPS_SEL_C0 + c)
				ec[c*3 +: 3] = ec[c*3 +: 3] + d;
		fork
			u_core.step(u, s, n);
			wait_done();
		join
		chk({m_tap, c_tap}, {em, ec});
	endtask
	// every code down (wrapping) then up
	task automatic t_codes();
		for (int i = 0; i < 16; i++)
			step(i[3], i[2:0], 2);
	endtask
	// a long request still moves one tap
	task automatic t_long();
		step(1'b1, PPS_SEL_M, 7);
	endtask
	// reset mid-run clears taps, then steps again
	task automatic t_reset();
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		em = 3'h0;
		ec = 15'h0;
		chk({m_tap, c_tap}, 18'h0);
		chk(18'(step_done), 18'h1);
		step(1'b1, PPS_SEL_C4, 3);
	endtask
	initial begin
		rst = 1'b1;
		num_errors = 0;
		total_checks = 0;
		em = 3'h0;
		ec = 15'h0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_codes();
		t_long();
		t_reset();
		report_and_stop();
	end
endmodule
